// file: verilog/aap_pkg.sv
// constants for the autonegotiation advertisement, partner and expansion registers
// assumes a 16-bit management register port with 5-bit register numbers
package aap_pkg;

	// ============================================================
	// register numbers
	localparam logic [4:0]  AAP_REG_ADVERT    = 5'h04;
	localparam logic [4:0]  AAP_REG_PARTNER   = 5'h05;
	localparam logic [4:0]  AAP_REG_EXPANSION = 5'h06;

	// ============================================================
	// local advertisement fields
	localparam int          AAP_ADV_MORE_PAGES   = 15;
	localparam int          AAP_ADV_CONFIRM      = 14;
	localparam int          AAP_ADV_REMOTE_FAULT = 13;
	localparam int          AAP_ADV_PAUSE        = 10;
	localparam int          AAP_ADV_T4           = 9;
	localparam int          AAP_ADV_TX_FD        = 8;
	localparam int          AAP_ADV_TX           = 7;
	localparam int          AAP_ADV_10_FD        = 6;
	localparam int          AAP_ADV_10           = 5;
	localparam int          AAP_CLASS_MSB        = 4;
	localparam int          AAP_CLASS_LSB        = 0;
	// bits 12:11 are reserved: not stored, read as zero
	localparam logic [15:0] AAP_ADV_WRITE_MASK   = 16'he7ff;
	// protocol class 00001, abilities 100 fd, 100, 10 fd, 10 advertised
	localparam logic [15:0] AAP_ADV_RESET        = 16'h01e1;

	// ============================================================
	// partner page fields, both views
	localparam int          AAP_LP_MORE_PAGES    = 15;
	localparam int          AAP_LP_CONFIRM       = 14;
	localparam int          AAP_LP_FAULT         = 13;
	localparam int          AAP_LP_MESSAGE       = 13;
	localparam int          AAP_LP_COMPLY        = 12;
	localparam int          AAP_LP_ALTERNATOR    = 11;
	localparam int          AAP_LP_CAP_MSB       = 12;
	localparam int          AAP_LP_CAP_LSB       = 5;
	localparam int          AAP_LP_CODE_MSB      = 10;
	localparam int          AAP_LP_CODE_LSB      = 0;
	localparam logic [15:0] AAP_LP_RESET         = 16'h0000;

	// ============================================================
	// expansion fields
	localparam int          AAP_EXP_PAR_ERR      = 4;
	localparam int          AAP_EXP_LP_EXTRA     = 3;
	localparam int          AAP_EXP_LOCAL_EXTRA  = 2;
	localparam int          AAP_EXP_PAGE_ARRIVED = 1;
	localparam int          AAP_EXP_LP_NEG_CAP   = 0;
	localparam int          AAP_FLAG_COUNT       = 2;
	localparam int          AAP_FLAG_PAR_ERR     = 0;
	localparam int          AAP_FLAG_PAGE        = 1;

endpackage

// file: verilog/aap_sticky.sv
// one latched-high status flag
// assumes set and clear are single-cycle pulses on clk
`timescale 1ns/100ps
module aap_sticky (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic set,
	input  wire logic clear,
	output logic      flag
);

	// ============================================================
	// latch
	// set wins so an event landing on the clearing read is not lost
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flag <= 1'b0;
		end else if (set) begin
			flag <= 1'b1;
		end else if (clear) begin
			flag <= 1'b0;
		end
	end

endmodule

// file: verilog/aap_regs.sv
// advertisement, link partner and expansion registers of one port
// assumes register port and negotiation inputs come from logic on clk
`timescale 1ns/100ps

// How it works
// - writing advertised more-pages bit enables next-page exchange after the base page
// - advertisement holds a writable confirm bit sent in the local code word
// - remote fault advert bit is sent to the partner in the code word
// - pause bit advertises wish to exchange flow control
// - ability bits 8 to 5 are advertised when set
// - protocol class field resets to 00001
// - base view bit 14 shows partner saw three consistent bursts
// - base view shows partner abilities 12:5 and protocol class 4:0
// - base view bit 13 shows the partner fault
// - next view shows more pages, message flag and comply flag
// - next view bit 14 shows partner received our code word
// - next view bit 11 shows the partner alternator as received
// - next view low eleven bits carry the partner code field
// - parallel detection error latches high, cleared only by expansion read
// - page arrived latches high when a next page is received
// - local extra-page-capable bit always reads one
// - expansion bit 3 partner next-page support, bit 0 partner negotiation capable
// - latched flags hold until their register is read
// - partner contents read zero until negotiation completes
module aap_regs
	import aap_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [4:0]  mgmt_addr,
	input  wire logic        mgmt_wr,
	input  wire logic [15:0] mgmt_wdata,
	input  wire logic        mgmt_rd,
	output logic      [15:0] mgmt_rdata,
	input  wire logic        rx_page_valid,
	input  wire logic        rx_page_is_next,
	input  wire logic [15:0] rx_page_word,
	input  wire logic        partner_negotiation_capable,
	input  wire logic        parallel_detection_event,
	input  wire logic        negotiation_complete,
	output logic      [15:0] tx_base_word,
	output logic             next_page_enable,
	output logic             partner_view_next
);

	// ============================================================
	// state
	logic [15:0] local_advertisement;
	logic [15:0] partner_word;
	logic        partner_extra_page_capable;
	logic [AAP_FLAG_COUNT-1:0] flag_set;
	logic [AAP_FLAG_COUNT-1:0] flag_q;
	logic        expansion_read;
	logic [15:0] partner_base_page;
	logic [15:0] partner_next_page_view;
	logic [15:0] negotiation_expansion;
	logic [15:0] next_rdata;

	function automatic logic hit(input logic [4:0] addr, input logic [4:0] reg_num);
		hit = (addr == reg_num);
	endfunction

	// ============================================================
	// local advertisement
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			local_advertisement <= AAP_ADV_RESET;
		end else if (mgmt_wr && hit(mgmt_addr, AAP_REG_ADVERT)) begin
			local_advertisement <= mgmt_wdata & AAP_ADV_WRITE_MASK;
		end
	end

	// word straight from the register so the burst generator sees changes at once
	assign tx_base_word     = local_advertisement;
	// pause, T4 and abilities travel in the same word untouched
	assign next_page_enable = local_advertisement[AAP_ADV_MORE_PAGES];

	// ============================================================
	// partner page capture
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			partner_word      <= AAP_LP_RESET;
			partner_view_next <= 1'b0;
		end else if (rx_page_valid) begin
			partner_word      <= rx_page_word;
			partner_view_next <= rx_page_is_next;
		end
	end

	// next-page support is only meaningful from the base page
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			partner_extra_page_capable <= 1'b0;
		end else if (rx_page_valid && !rx_page_is_next) begin
			partner_extra_page_capable <= rx_page_word[AAP_LP_MORE_PAGES];
		end
	end

	always_comb begin
		partner_base_page = 16'h0000;
		partner_base_page[AAP_LP_MORE_PAGES] = partner_word[AAP_LP_MORE_PAGES];
		partner_base_page[AAP_LP_CONFIRM]    = partner_word[AAP_LP_CONFIRM];
		partner_base_page[AAP_LP_FAULT]      = partner_word[AAP_LP_FAULT];
		partner_base_page[AAP_LP_CAP_MSB:AAP_LP_CAP_LSB] =
			partner_word[AAP_LP_CAP_MSB:AAP_LP_CAP_LSB];
		partner_base_page[AAP_CLASS_MSB:AAP_CLASS_LSB] =
			partner_word[AAP_CLASS_MSB:AAP_CLASS_LSB];
	end

	always_comb begin
		partner_next_page_view = 16'h0000;
		partner_next_page_view[AAP_LP_MORE_PAGES] = partner_word[AAP_LP_MORE_PAGES];
		partner_next_page_view[AAP_LP_CONFIRM]    = partner_word[AAP_LP_CONFIRM];
		partner_next_page_view[AAP_LP_MESSAGE]    = partner_word[AAP_LP_MESSAGE];
		partner_next_page_view[AAP_LP_COMPLY]     = partner_word[AAP_LP_COMPLY];
		partner_next_page_view[AAP_LP_ALTERNATOR] = partner_word[AAP_LP_ALTERNATOR];
		partner_next_page_view[AAP_LP_CODE_MSB:AAP_LP_CODE_LSB] =
			partner_word[AAP_LP_CODE_MSB:AAP_LP_CODE_LSB];
	end

	// ============================================================
	// latched-high flags
	assign expansion_read = mgmt_rd && hit(mgmt_addr, AAP_REG_EXPANSION);
	assign flag_set[AAP_FLAG_PAR_ERR] = parallel_detection_event;
	assign flag_set[AAP_FLAG_PAGE]    = rx_page_valid && rx_page_is_next;

	genvar gi;
	generate
		for (gi = 0; gi < AAP_FLAG_COUNT; gi++) begin : g_flag
			aap_sticky u_flag (
				.clk   (clk),
				.nrst  (nrst),
				.set   (flag_set[gi]),
				.clear (expansion_read),
				.flag  (flag_q[gi])
			);
		end
	endgenerate

	always_comb begin
		negotiation_expansion = 16'h0000;
		negotiation_expansion[AAP_EXP_PAR_ERR]      = flag_q[AAP_FLAG_PAR_ERR];
		negotiation_expansion[AAP_EXP_LP_EXTRA]     =
			partner_extra_page_capable && negotiation_complete;
		negotiation_expansion[AAP_EXP_LOCAL_EXTRA]  = 1'b1;
		negotiation_expansion[AAP_EXP_PAGE_ARRIVED] = flag_q[AAP_FLAG_PAGE];
		negotiation_expansion[AAP_EXP_LP_NEG_CAP]   =
			partner_negotiation_capable && negotiation_complete;
	end

	// ============================================================
	// read path
	// partner data is hidden until negotiation completes; latched flags stay
	// visible so a clearing read never discards an unseen event
	always_comb begin
		next_rdata = 16'h0000;
		if (hit(mgmt_addr, AAP_REG_ADVERT)) begin
			next_rdata = local_advertisement;
		end else if (hit(mgmt_addr, AAP_REG_PARTNER) && negotiation_complete) begin
			next_rdata = partner_view_next ? partner_next_page_view
			                               : partner_base_page;
		end else if (hit(mgmt_addr, AAP_REG_EXPANSION)) begin
			next_rdata = negotiation_expansion;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mgmt_rdata <= 16'h0000;
		end else if (mgmt_rd) begin
			mgmt_rdata <= next_rdata;
		end
	end

endmodule

// file: tb/aap_partner.sv
// link partner model: hands received code words to the page capture inputs
// assumes the bench calls send between register accesses, clk from the bench
`timescale 1ns/100ps
module aap_partner (
	input  wire logic        clk,
	output logic             rx_page_valid,
	output logic             rx_page_is_next,
	output logic      [15:0] rx_page_word,
	output logic             partner_negotiation_capable
);
	// ====
	// page delivery
	initial begin
		rx_page_valid = 0;
		rx_page_is_next = 0;
		rx_page_word = 16'h0;
		partner_negotiation_capable = 0;
	end
	task send(input logic nxt, input logic [15:0] w);
		@(negedge clk);
		rx_page_valid = 1;
		rx_page_is_next = nxt;
		rx_page_word = w | 16'h4000;
		partner_negotiation_capable = 1;
		@(negedge clk);
		rx_page_valid = 0;
		rx_page_is_next = ~nxt;
		// released word shows the inverse, so a stale capture cannot pass
		rx_page_word = ~rx_page_word;
	endtask
endmodule

// file: tb/aap_regs_chk.sv
// checker for aap_regs: register port, page capture, latched flags
// assumes it is bound to aap_regs and sees only its ports
`timescale 1ns/100ps
module aap_regs_chk
	import aap_pkg::*;
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [4:0]  mgmt_addr,
	input wire logic        mgmt_wr,
	input wire logic [15:0] mgmt_wdata,
	input wire logic        mgmt_rd,
	input wire logic [15:0] mgmt_rdata,
	input wire logic        rx_page_valid,
	input wire logic        rx_page_is_next,
	input wire logic [15:0] rx_page_word,
	input wire logic        partner_negotiation_capable,
	input wire logic        parallel_detection_event,
	input wire logic        negotiation_complete,
	input wire logic [15:0] tx_base_word,
	input wire logic        next_page_enable,
	input wire logic        partner_view_next
);
	// ====
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	wire logic wr4 = mgmt_wr && mgmt_addr == AAP_REG_ADVERT;
	wire logic rd5 = mgmt_rd && mgmt_addr == AAP_REG_PARTNER;
	wire logic rd6 = mgmt_rd && mgmt_addr == AAP_REG_EXPANSION;
	wire logic set = parallel_detection_event || rx_page_valid && rx_page_is_next;
	a_adv_reset: assert property ($rose(nrst) |-> tx_base_word == AAP_ADV_RESET)
		else $error("bad advert reset");
	a_adv_write: assert property (wr4 |=>
		tx_base_word == ($past(mgmt_wdata) & AAP_ADV_WRITE_MASK)
		&& next_page_enable == $past(mgmt_wdata[15])) else $error("bad advert write");
	a_view_follow: assert property (rx_page_valid |=>
		partner_view_next == $past(rx_page_is_next)) else $error("bad view");
	a_partner_word: assert property (rx_page_valid ##1 !rx_page_valid ##1
		rd5 && negotiation_complete |=> mgmt_rdata == $past(rx_page_word, 3))
		else $error("bad partner word");
	a_partner_gate: assert property (rd5 && !negotiation_complete |=>
		mgmt_rdata == 16'h0) else $error("partner read not gated");
	a_exp_fixed: assert property (rd6 |=> mgmt_rdata[15:5] == 11'h0 &&
		mgmt_rdata[2] && mgmt_rdata[0] == $past(partner_negotiation_capable
		&& negotiation_complete)) else $error("bad expansion bits");
	a_par_latch: assert property (parallel_detection_event ##1 !rd6 ##1 rd6
		|=> mgmt_rdata[AAP_EXP_PAR_ERR]) else $error("error flag lost");
	a_page_latch: assert property (rx_page_valid && rx_page_is_next ##1 !rd6
		##1 rd6 |=> mgmt_rdata[AAP_EXP_PAGE_ARRIVED]) else $error("page flag lost");
	a_flag_clear: assert property (rd6 && !set ##1 !set ##1 rd6 |=>
		!mgmt_rdata[4] && !mgmt_rdata[1]) else $error("flag not cleared");
	c_next_page: cover property (rx_page_valid && rx_page_is_next);
	c_set_on_read: cover property (rd6 && parallel_detection_event);
	c_partner_read: cover property (rd5 && negotiation_complete);
endmodule
bind aap_regs aap_regs_chk aap_regs_chk_i (.*);

// file: tb/testbench.sv
// self-checking bench for aap_regs with the partner model on its page inputs
// assumes one 25 MHz clock; inputs change on the falling edge
`timescale 1ns/100ps
module testbench;
	import aap_pkg::*;
	logic        clk, nrst, mgmt_wr, mgmt_rd, parallel_detection_event;
	logic        negotiation_complete, next_page_enable, partner_view_next;
	logic        rx_page_valid, rx_page_is_next, partner_negotiation_capable;
	logic [4:0]  mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata, rx_page_word, tx_base_word, w, b;
	int          failures, check_count;
	aap_partner aap_partner_i (.*);
	aap_regs aap_regs_i (.*);
	always #20 clk = ~clk;
	// ====
	// tasks
	task cmp(input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk) {mgmt_addr, mgmt_wdata, mgmt_wr} = {a, d, 1'b1};
		@(negedge clk) mgmt_wr = 0;
	endtask
	task rd(input logic [4:0] a, input logic [15:0] e);
		@(negedge clk) {mgmt_addr, mgmt_rd} = {a, 1'b1};
		@(negedge clk) mgmt_rd = 0;
		cmp(e, mgmt_rdata);
	endtask
	function automatic logic [15:0] exp6(input logic p, l, g, c);
		return {11'h0, p, l & negotiation_complete, 1'b1, g, c & negotiation_complete};
	endfunction
	task conclude;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#4000000 failures++;
		conclude;
	end
	// ====
	// main sequence
	initial begin
		{clk, nrst, mgmt_wr, mgmt_rd, parallel_detection_event} = 0;
		{negotiation_complete, mgmt_addr, mgmt_wdata, failures, check_count} = 0;
		w = 16'($urandom(32'h75e8));
		repeat (8) @(posedge clk);
		@(negedge clk) nrst = 1;
		cmp(16'h01e1, tx_base_word);
		rd(5'h04, 16'h01e1);
		rd(5'h05, 16'h0);
		rd(5'h06, exp6(0, 0, 0, 0));
		rd(5'h1f, 16'h0);
		for (int i = 0; i < 6; i++) begin
			w = (i == 0) ? 16'hfdff : 16'($urandom) & 16'hfdff;
			wr(5'h04, w);
			cmp(w & 16'he7ff, tx_base_word);
			cmp({15'h0, w[15]}, {15'h0, next_page_enable});
			rd(5'h04, w & 16'he7ff);
		end
		wr(5'h05, 16'hffff);
		wr(5'h06, 16'hffff);
		negotiation_complete = 1;
		rd(5'h05, 16'h0);
		b = 16'($urandom) | 16'h8000;
		aap_partner_i.send(0, b);
		cmp(16'h0, {15'h0, partner_view_next});
		rd(5'h05, b | 16'h4000);
		rd(5'h06, exp6(0, 1, 0, 1));
		for (int i = 0; i < 3; i++) begin
			w = 16'($urandom);
			w[15] = (i != 2);
			w[11] = b[11] ^ !i[0];
			aap_partner_i.send(1, w);
			cmp(16'h1, {15'h0, partner_view_next});
			rd(5'h06, exp6(0, 1, 1, 1));
			rd(5'h05, w | 16'h4000);
			rd(5'h06, exp6(0, 1, 0, 1));
		end
		fork
			rd(5'h06, exp6(0, 1, 0, 1));
			begin
				@(negedge clk) parallel_detection_event = 1;
				@(negedge clk) parallel_detection_event = 0;
			end
		join
		rd(5'h06, exp6(1, 1, 0, 1));
		rd(5'h06, exp6(0, 1, 0, 1));
		negotiation_complete = 0;
		rd(5'h05, 16'h0);
		rd(5'h06, exp6(0, 1, 0, 1));
		nrst = 0;
		#5 cmp(16'h01e1, tx_base_word);
		@(negedge clk) nrst = 1;
		cmp(16'h0, {15'h0, partner_view_next});
		rd(5'h04, 16'h01e1);
		rd(5'h06, exp6(0, 0, 0, 0));
		negotiation_complete = 1;
		rd(5'h05, 16'h0);
		rd(5'h06, exp6(0, 0, 0, 1));
		conclude;
	end
endmodule
